// >>> rtl/dsac_regs.svh
// constants for the dual two-wire slave with alert logic
// assumes it is included by its bare name from every file that needs it
`ifndef DSAC_REGS_SVH
`define DSAC_REGS_SVH

// packet check code
`define DSAC_CRC_POLY 8'h07
`define DSAC_CRC_INIT 8'h00
`define DSAC_CRC_RESIDUE 8'h00

// addressing and commands
`define DSAC_SLAVE_ADDR 7'h58
`define DSAC_CMD_CLEAR 8'h03
`define DSAC_CMD_STATUS 8'h78
`define DSAC_PORT_DEFAULT 1'b0
`define DSAC_STATUS_RST 8'h00
`define DSAC_BIT_LAST 4'h8
`define DSAC_TX_LAST 4'h7
`define DSAC_NBYTE_MAX 4'hf
`define DSAC_NBYTE_PEC 4'h3

// serial rates; oversampling keeps both inside the link clock budget
`define DSAC_RATE_DEFAULT_KHZ 100
`define DSAC_RATE_FAST_KHZ 400

// timing, in own units, and counts of link clock cycles
`define DSAC_LNK_PERIOD_NS 64
`define DSAC_STRETCH_MAX_MS 25
`define DSAC_LOCKUP_MS 35
`define DSAC_IDLE_S 5
`define DSAC_STRETCH_CYC \
  ((`DSAC_STRETCH_MAX_MS * 1000000) / `DSAC_LNK_PERIOD_NS)
`define DSAC_LOCKUP_CYC \
  ((`DSAC_LOCKUP_MS * 1000000 + `DSAC_LNK_PERIOD_NS - 1) / `DSAC_LNK_PERIOD_NS)
`define DSAC_IDLE_CYC \
  ((`DSAC_IDLE_S * 64'd1000000000) / `DSAC_LNK_PERIOD_NS)

`endif

// >>> rtl/dsac_pkg.sv
// types shared by the dual two-wire slave files
// assumes nothing of its surroundings
package dsac_pkg;
  typedef enum logic [5:0]
  {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_RACK = 6'h10,
    ST_WAIT = 6'h20
  } dsac_state_t;
  typedef logic [7:0] dsac_byte_t;
endpackage

// >>> rtl/dsac_crc_if.sv
// carrier between the transaction engine and the check-code unit
// assumes both ends run on the link clock
`timescale 1ns/1ps
interface dsac_crc_if;
  logic init;
  logic valid;
  dsac_pkg::dsac_byte_t data;
  dsac_pkg::dsac_byte_t crc;
  modport engine (output init, output valid, output data, input crc);
  modport calc (input init, input valid, input data, output crc);
endinterface

// >>> rtl/dsac_crc8.sv
// running 8-bit packet check code, one byte per valid pulse
// assumes a synchronous active-low reset on its clock
`timescale 1ns/1ps
`include "dsac_regs.svh"
module dsac_crc8
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // engine side
  dsac_crc_if.calc crc_if
);
  import dsac_pkg::*;

  dsac_byte_t crc_reg;

  function automatic dsac_byte_t crc_step(dsac_byte_t c, dsac_byte_t d);
    dsac_byte_t x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      x = x[7] ? ({x[6:0], 1'b0} ^ `DSAC_CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction

  assign crc_if.crc = crc_reg;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || crc_if.init)
      crc_reg <= `DSAC_CRC_INIT;
    else if (crc_if.valid)
      crc_reg <= crc_step(crc_reg, crc_if.data); // see (R7)
  end
endmodule

// >>> rtl/dsac_top.sv
// dual two-wire management slave with latched alert pins
// assumes i_rst_n synchronous to i_clk; i_lnk_clk free running, unrelated
// Summary of operation
// (R1) a clock stretch is released within 25 ms at the latest
// (R2) host waits while the clock is held low or past the stretch limit
// (R3) stretch only after the ninth bit of a byte, never elsewhere
// (R4) bus held low over 35 ms aborts the transfer, both lines released
// (R5) works at 100 kHz and 400 kHz, 100 kHz is the default
// (R6) commands lacking a trailing check byte are ignored
// (R7) check byte is a CRC-8 with polynomial x^8 + x^2 + x + 1
// (R8) check covers every byte, address and command before a restart too
// (R9) last data sender appends the check byte, device does so on reads
// (R10) one alert request drives both alert pins; selector may add its own
// (R11) alert idles high, goes low on a change, latched until clear-faults
// (R12) any state change, fault or communication error raises the alert
// (R13) both alert pins asserted at power-up
// (R14) alert released only by clear-faults or a bias power cycle
// (R15) alert re-asserts on any internal change, including the clear refresh
// (R16) host clears, reads status, then clears again
// (R17) serial logic re-initializes after 5 s without bus activity
// (R18) host waits over 2 s after an alert before reading back
// (R19) host spaces read-backs at least one second apart
// (R20) two independent ports; a faulty one leaves the other working
// (R21) port 0 is selected after power-up
// (R22) a single host sits on port 0; port 1 then stays unused
// (R23) reads of unsupported commands return zero
// (R24) clear-faults clears status; persisting conditions set again at once
// (R25) device is a slave only, drives no clock beyond stretching
`timescale 1ns/1ps
`include "dsac_regs.svh"
module dsac_top
#(
  parameter int unsigned P_STRETCH_CYC = `DSAC_STRETCH_CYC,
  parameter int unsigned P_LOCKUP_CYC = `DSAC_LOCKUP_CYC,
  parameter int unsigned P_IDLE_CYC = 32'(`DSAC_IDLE_CYC)
)
(
  // system clock domain
  input wire logic i_clk,
  input wire logic i_rst_n,
  // link clock
  input wire logic i_lnk_clk,
  // state-change sources and the busy hold-off, levels on i_clk
  input wire logic i_vin_fault,
  input wire logic i_vout_fault,
  input wire logic i_overcurrent_fault_flag,
  input wire logic i_fan_fault,
  input wire logic i_temp_fault,
  input wire logic i_internal_fault,
  input wire logic i_busy,
  // two-wire ports
  input wire logic [1:0] i_scl,
  output logic [1:0] o_scl_o,
  output logic [1:0] o_scl_oe,
  input wire logic [1:0] i_sda,
  output logic [1:0] o_sda_o,
  output logic [1:0] o_sda_oe,
  // alert pins, open drain
  output logic [1:0] o_alert_n_o,
  output logic [1:0] o_alert_n_oe,
  // status
  output dsac_pkg::dsac_byte_t o_status,
  output logic o_port_sel
);
  import dsac_pkg::*;

  // ---------------- link domain ----------------
  logic lrst_meta_reg, lrst_n_reg;
  logic [1:0] scl_s, scl_p, sda_s, sda_p;
  logic busy_meta_reg, busy_s_reg;
  logic ack_meta_reg, ack_s_reg, ack_p_reg;
  logic sel_reg;
  dsac_state_t state_reg;
  logic [3:0] bit_reg, nbyte_reg;
  dsac_byte_t shift_reg, cmd_reg;
  logic rd_reg, rep_reg, phase_reg, nack_reg, drive_reg;
  logic stretch_req_reg, stretch_reg, pending_reg;
  logic snap_tgl_reg, clr_tgl_reg, err_tgl_reg;
  logic crc_init_reg, crc_val_reg;
  dsac_byte_t crc_dat_reg;
  logic [31:0] stretch_cnt_reg, low_cnt_reg, idle_cnt_reg;
  // ---------------- system domain ----------------
  logic [3:0] x_meta_reg, x_sync_reg, x_prev_reg;
  dsac_byte_t status_reg, status_prev_reg, snap_reg;
  logic [5:0] cond_prev_reg;
  logic alert_reg, snap_ack_tgl_reg;
  logic [1:0] sel_alert_reg;

  dsac_crc_if crc_if ();

  dsac_crc8 u_crc
  (
    .i_clk(i_lnk_clk),
    .i_rst_n(lrst_n_reg),
    .crc_if(crc_if.calc)
  );

  assign crc_if.init = crc_init_reg;
  assign crc_if.valid = crc_val_reg;
  assign crc_if.data = crc_dat_reg;

  // the link side gets its own reset copy so release is clean there
  always_ff @(posedge i_lnk_clk)
  begin
    lrst_meta_reg <= i_rst_n;
    lrst_n_reg <= lrst_meta_reg;
  end

  // both ports are watched all the time; a dead one cannot stall the other
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_port
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    always_ff @(posedge i_lnk_clk)
    begin
      scl_meta_reg <= i_scl[gi];
      sda_meta_reg <= i_sda[gi];
      if (!lrst_n_reg)
      begin
        scl_sync_reg <= 1'b1;
        sda_sync_reg <= 1'b1;
        scl_prev_reg <= 1'b1;
        sda_prev_reg <= 1'b1;
      end
      else
      begin
        scl_sync_reg <= scl_meta_reg;
        sda_sync_reg <= sda_meta_reg;
        scl_prev_reg <= scl_sync_reg;
        sda_prev_reg <= sda_sync_reg;
      end
    end
    assign scl_s[gi] = scl_sync_reg;
    assign scl_p[gi] = scl_prev_reg;
    assign sda_s[gi] = sda_sync_reg;
    assign sda_p[gi] = sda_prev_reg; // see (R20)
  end

  // 64 ns sampling gives ~39 samples per bit even at 400 kHz; see (R5)
  wire logic [1:0] scl_rise = scl_s & ~scl_p;
  wire logic [1:0] scl_fall = ~scl_s & scl_p;
  wire logic [1:0] start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire logic [1:0] stop_det = scl_s & scl_p & ~sda_p & sda_s;
  wire logic [1:0] sel_onehot = {sel_reg, ~sel_reg};
  wire logic s_scl_r = scl_rise[sel_reg];
  wire logic s_scl_f = scl_fall[sel_reg];
  wire logic s_start = start_det[sel_reg];
  wire logic s_stop = stop_det[sel_reg];
  wire logic s_sda = sda_s[sel_reg];
  wire logic s_low = ~scl_s[sel_reg] | ~sda_s[sel_reg];
  wire logic any_act = |((scl_s ^ scl_p) | (sda_s ^ sda_p));
  wire logic idle_w = (state_reg == ST_IDLE);
  wire logic start_w = idle_w ? (|start_det) : s_start;
  wire logic abort_w = (low_cnt_reg == P_LOCKUP_CYC - 1);
  wire logic reinit_w = (idle_cnt_reg == P_IDLE_CYC - 1);
  wire logic ack_ev = ack_s_reg ^ ack_p_reg;
  wire logic ready_w = ~pending_reg & ~busy_s_reg;
  wire logic crc_ok_w = (crc_if.crc == `DSAC_CRC_RESIDUE);
  wire logic repeat_w = ~idle_w & (nbyte_reg == 4'h2) & ~rd_reg;
  wire logic status_rd_w = rep_reg & (cmd_reg == `DSAC_CMD_STATUS);
  // only the status command has read data here; see (R23)
  wire dsac_byte_t tx_data_w = status_rd_w ? snap_reg : 8'h00;
  wire logic addr_hit_w = (shift_reg[7:1] == `DSAC_SLAVE_ADDR);
  wire logic wr_eval_w = ~idle_w & (state_reg != ST_WAIT) & ~rd_reg &
                         (nbyte_reg >= `DSAC_NBYTE_PEC);
  wire logic [3:0] nbyte_inc = (nbyte_reg == `DSAC_NBYTE_MAX) ?
                               nbyte_reg : nbyte_reg + 4'h1;

  always_ff @(posedge i_lnk_clk)
  begin
    busy_meta_reg <= i_busy;
    ack_meta_reg <= snap_ack_tgl_reg;
    if (!lrst_n_reg)
    begin
      busy_s_reg <= 1'b0;
      ack_s_reg <= 1'b0;
      ack_p_reg <= 1'b0;
    end
    else
    begin
      busy_s_reg <= busy_meta_reg;
      ack_s_reg <= ack_meta_reg;
      ack_p_reg <= ack_s_reg;
    end
  end

  // transaction engine; slave only, it never makes clock edges; see (R25)
  always_ff @(posedge i_lnk_clk)
  begin
    crc_init_reg <= 1'b0;
    crc_val_reg <= 1'b0;
    stretch_req_reg <= 1'b0;
    if (!lrst_n_reg)
    begin
      sel_reg <= `DSAC_PORT_DEFAULT; // see (R21)
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      nbyte_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      rd_reg <= 1'b0;
      rep_reg <= 1'b0;
      phase_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
      pending_reg <= 1'b0;
      snap_tgl_reg <= 1'b0;
      clr_tgl_reg <= 1'b0;
      err_tgl_reg <= 1'b0;
      crc_dat_reg <= 8'h00;
    end
    else if (abort_w || reinit_w)
    begin
      state_reg <= ST_IDLE; // see (R4) (R17)
      drive_reg <= 1'b0;
      nbyte_reg <= 4'h0;
    end
    else
    begin
      if (ack_ev)
        pending_reg <= 1'b0;
      if (start_w)
      begin
        // an idle engine follows whichever host starts; see (R20)
        if (idle_w)
          sel_reg <= ~start_det[0];
        rep_reg <= repeat_w;
        crc_init_reg <= ~repeat_w; // see (R8)
        state_reg <= ST_RX;
        bit_reg <= 4'h0;
        nbyte_reg <= 4'h0;
        phase_reg <= 1'b0;
        drive_reg <= 1'b0;
      end
      else if (s_stop)
      begin
        // a write counts only with a good trailing check byte; see (R6)
        if (wr_eval_w)
        begin
          if (!crc_ok_w || cmd_reg != `DSAC_CMD_CLEAR)
            err_tgl_reg <= ~err_tgl_reg; // see (R12)
          else if (nbyte_reg == `DSAC_NBYTE_PEC)
            clr_tgl_reg <= ~clr_tgl_reg;
        end
        state_reg <= ST_IDLE;
        drive_reg <= 1'b0;
        nbyte_reg <= 4'h0;
      end
      else
      begin
        case (state_reg)
          ST_RX:
          begin
            if (s_scl_r)
            begin
              shift_reg <= {shift_reg[6:0], s_sda};
              bit_reg <= bit_reg + 4'h1;
            end
            else if (s_scl_f && bit_reg == `DSAC_BIT_LAST)
            begin
              crc_val_reg <= 1'b1; // see (R8)
              crc_dat_reg <= shift_reg;
              bit_reg <= 4'h0;
              if (nbyte_reg == 4'h0 && !addr_hit_w)
                state_reg <= ST_WAIT;
              else
              begin
                state_reg <= ST_ACK;
                drive_reg <= 1'b1;
                nbyte_reg <= nbyte_inc;
                if (nbyte_reg == 4'h0)
                  rd_reg <= shift_reg[0];
                if (nbyte_reg == 4'h1 && !rd_reg)
                begin
                  cmd_reg <= shift_reg;
                  if (shift_reg == `DSAC_CMD_STATUS)
                  begin
                    pending_reg <= 1'b1;
                    snap_tgl_reg <= ~snap_tgl_reg;
                  end
                end
              end
            end
          end
          ST_ACK:
          begin
            if (s_scl_f)
            begin
              drive_reg <= 1'b0;
              stretch_req_reg <= ~ready_w; // see (R3)
              if (rd_reg)
              begin
                state_reg <= ST_TX;
                shift_reg <= tx_data_w;
                drive_reg <= ~tx_data_w[7];
                crc_val_reg <= 1'b1;
                crc_dat_reg <= tx_data_w;
              end
              else
                state_reg <= ST_RX;
            end
          end
          ST_TX:
          begin
            if (s_scl_f)
            begin
              if (bit_reg == `DSAC_TX_LAST)
              begin
                drive_reg <= 1'b0;
                bit_reg <= 4'h0;
                state_reg <= ST_RACK;
              end
              else
              begin
                bit_reg <= bit_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                drive_reg <= ~shift_reg[6];
              end
            end
          end
          ST_RACK:
          begin
            if (s_scl_r)
              nack_reg <= s_sda;
            else if (s_scl_f)
            begin
              if (nack_reg || phase_reg)
                state_reg <= ST_WAIT;
              else
              begin
                phase_reg <= 1'b1; // see (R9)
                shift_reg <= crc_if.crc;
                drive_reg <= ~crc_if.crc[7];
                state_reg <= ST_TX;
              end
            end
          end
          ST_WAIT:
            drive_reg <= 1'b0;
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // stretch limit counts from the request, the pin lags by one cycle
  always_ff @(posedge i_lnk_clk)
  begin
    if (!lrst_n_reg || abort_w || reinit_w)
    begin
      stretch_reg <= 1'b0;
      stretch_cnt_reg <= 32'h0;
    end
    else if (stretch_req_reg)
    begin
      stretch_reg <= 1'b1;
      stretch_cnt_reg <= 32'h0;
    end
    else if (stretch_reg)
    begin
      if (ready_w || stretch_cnt_reg == P_STRETCH_CYC - 1)
        stretch_reg <= 1'b0; // see (R1)
      stretch_cnt_reg <= stretch_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge i_lnk_clk)
  begin
    if (!lrst_n_reg || !s_low || abort_w)
      low_cnt_reg <= 32'h0;
    else
      low_cnt_reg <= low_cnt_reg + 32'h1; // see (R4)
    if (!lrst_n_reg || any_act || reinit_w)
      idle_cnt_reg <= 32'h0;
    else
      idle_cnt_reg <= idle_cnt_reg + 32'h1; // see (R17)
  end

  always_ff @(posedge i_lnk_clk)
  begin
    if (!lrst_n_reg)
    begin
      o_scl_oe <= 2'h0;
      o_sda_oe <= 2'h0;
      o_port_sel <= `DSAC_PORT_DEFAULT;
    end
    else
    begin
      o_scl_oe <= {2{stretch_reg}} & sel_onehot;
      o_sda_oe <= {2{drive_reg}} & sel_onehot;
      o_port_sel <= sel_reg;
    end
    o_scl_o <= 2'h0;
    o_sda_o <= 2'h0;
  end

  // ---------------- system domain logic ----------------
  wire logic [3:0] x_in = {snap_tgl_reg, clr_tgl_reg, err_tgl_reg, sel_reg};
  wire logic [3:0] x_ev = x_sync_reg ^ x_prev_reg;
  wire logic snap_ev = x_ev[3];
  wire logic clr_ev = x_ev[2];
  wire logic err_ev = x_ev[1];
  wire logic sel_ev = x_ev[0];
  wire logic [5:0] cond = {i_internal_fault, i_temp_fault, i_fan_fault,
                           i_overcurrent_fault_flag, i_vout_fault,
                           i_vin_fault};
  // set wins over clear so a persisting fault stays visible; see (R24)
  wire dsac_byte_t status_next = (clr_ev ? `DSAC_STATUS_RST : status_reg) |
                                 {1'b0, err_ev, cond};
  wire logic change_w = (cond != cond_prev_reg) | err_ev |
                        (status_reg != status_prev_reg); // see (R12) (R15)
  wire logic alert_next = change_w | (alert_reg & ~clr_ev); // see (R14)
  wire logic [1:0] lost_port = x_sync_reg[0] ? 2'b01 : 2'b10;
  wire logic [1:0] sel_alert_next = (clr_ev ? 2'b00 : sel_alert_reg) |
                                    (sel_ev ? lost_port : 2'b00);

  always_ff @(posedge i_clk)
  begin
    x_meta_reg <= x_in;
    if (!i_rst_n)
    begin
      x_sync_reg <= 4'h0;
      x_prev_reg <= 4'h0;
    end
    else
    begin
      x_sync_reg <= x_meta_reg;
      x_prev_reg <= x_sync_reg;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      status_reg <= `DSAC_STATUS_RST;
      status_prev_reg <= `DSAC_STATUS_RST;
      cond_prev_reg <= 6'h00;
      alert_reg <= 1'b1; // see (R13)
      sel_alert_reg <= 2'b00;
      o_alert_n_oe <= 2'b11;
      snap_reg <= 8'h00;
      snap_ack_tgl_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      status_prev_reg <= status_reg;
      cond_prev_reg <= cond;
      alert_reg <= alert_next; // see (R11)
      sel_alert_reg <= sel_alert_next;
      o_alert_n_oe <= {2{alert_reg}} | sel_alert_reg; // see (R10)
      if (snap_ev)
      begin
        snap_reg <= status_reg;
        snap_ack_tgl_reg <= ~snap_ack_tgl_reg;
      end
    end
    o_alert_n_o <= 2'b00;
    o_status <= status_reg;
  end

  // ---------------- checks ----------------
  sequence s_clear_seen;
    clr_ev;
  endsequence
  sequence s_status_moved;
    status_reg != status_prev_reg;
  endsequence

  chk_alert_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R11)
    alert_reg && !clr_ev |=> alert_reg)
    else $error("alert dropped without clear-faults");
  chk_alert_release: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R14)
    $fell(alert_reg) |-> $past(clr_ev))
    else $error("alert released without clear-faults");
  chk_alert_rearm: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R15)
    s_status_moved |=> alert_reg ##1 o_alert_n_oe == 2'b11)
    else $error("status change did not raise alert");
  chk_persist_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R24)
    s_clear_seen ##0 cond[2] |=> status_reg[2])
    else $error("persisting fault lost on clear");
  chk_stretch_bound: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R1)
    stretch_reg |-> stretch_cnt_reg < P_STRETCH_CYC)
    else $error("clock stretch over limit");
  chk_stretch_place: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R3)
    $rose(stretch_reg) |-> $past(state_reg, 2) == ST_ACK)
    else $error("stretch outside acknowledge end");
  chk_lockup_drop: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R4)
    abort_w |=> !drive_reg && !stretch_reg ##1 o_sda_oe == 2'h0 && o_scl_oe == 2'h0)
    else $error("lines not released after lock-up");
  chk_pec_gate: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R6)
    $changed(clr_tgl_reg) |-> $past(crc_ok_w) && $past(nbyte_reg) == 4'h3)
    else $error("clear accepted without valid check byte");
  chk_reinit_idle: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R17)
    reinit_w |=> state_reg == ST_IDLE)
    else $error("idle timeout did not re-initialize");
  chk_crc_tail: assert property (@(posedge i_lnk_clk) disable iff (!lrst_n_reg) // see (R9)
    $rose(phase_reg) |-> shift_reg == $past(crc_if.crc))
    else $error("appended byte is not the check code");
endmodule

// >>> verification/dsac_host_model.sv
// host controller model that can drive either two-wire port of the slave
// assumes the bench resolves the lines open drain with pull-ups
`timescale 1ns/1ps
module dsac_host_model
(
  // resolved lines
  input wire logic [1:0] i_scl,
  input wire logic [1:0] i_sda,
  // host drives, high means released
  output logic [1:0] o_scl,
  output logic [1:0] o_sda
);
  real q = 625.0; // quarter bit at 400 kHz
  int p = 0; // single-host traffic stays on port 0
  logic [1:0] gnd = 2'h0;
  logic [1:0] sc = 2'h3;
  logic [1:0] sd = 2'h3;
  logic [7:0] crc;
  logic nak;
  assign o_scl = sc;
  // gnd models a data wire shorted low
  assign o_sda = sd & ~gnd;
  function automatic logic [7:0] crc8(input logic [7:0] c,
    input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction
  task automatic hi;
    #q sc[p] = 1'b1;
    wait (i_scl[p] === 1'b1); // next edge waits out a stretch
  endtask
  task automatic bitx(input logic b, output logic r);
    sd[p] = b;
    hi;
    #q r = i_sda[p];
    #q sc[p] = 1'b0;
    #q;
  endtask
  task automatic start(input logic fresh);
    if (fresh)
    begin
      crc = 8'h00;
      nak = 1'b0;
    end
    sd[p] = 1'b1;
    hi;
    #q sd[p] = 1'b0;
    #q sc[p] = 1'b0;
  endtask
  task automatic stop;
    sd[p] = 1'b0;
    hi;
    #q sd[p] = 1'b1;
    #(4 * q);
  endtask
  task automatic send(input logic [7:0] d);
    logic r;
    crc = crc8(crc, d); // every byte counts, address too
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    nak = nak | r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(last, r);
    crc = crc8(crc, d);
  endtask
endmodule

// >>> verification/dsac_top_tb.sv
// self-checking bench for the dual two-wire slave with alert pins
// assumes the host model on both ports; lines resolve here
`timescale 1ns/1ps
`include "dsac_regs.svh"
module dsac_top_tb;
  import dsac_pkg::*;
  localparam logic [7:0] WA = {`DSAC_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RA = {`DSAC_SLAVE_ADDR, 1'b1};
  logic clk = 1'b0;
  logic lnk_clk = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic [5:0] flt = 6'h00;
  wire [1:0] hs, hd, scl, sda, scl_oe, sda_oe, alert;
  dsac_byte_t status;
  logic port_sel;
  int num_errors = 0;
  int checked = 0;
  int slen = 0;
  int smax = 0;
  always #4 clk = ~clk;
  initial #11 forever #32 lnk_clk = ~lnk_clk;
  // open drain with pull-ups: a released line reads high
  assign scl = hs & ~scl_oe;
  assign sda = hd & ~sda_oe;
  always @(posedge lnk_clk)
  begin
    slen = scl_oe[0] ? slen + 1 : 0;
    if (slen > smax)
      smax = slen;
  end
  // lock-up limit must outlast a stretch plus a long run of low data bits
  dsac_top #(.P_STRETCH_CYC(200), .P_LOCKUP_CYC(800), .P_IDLE_CYC(2000))
  i_dsac_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_lnk_clk(lnk_clk),
    .i_vin_fault(flt[0]), .i_vout_fault(flt[1]),
    .i_overcurrent_fault_flag(flt[2]), .i_fan_fault(flt[3]),
    .i_temp_fault(flt[4]), .i_internal_fault(flt[5]), .i_busy(busy),
    .i_scl(scl), .o_scl_o(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe),
    .o_alert_n_o(), .o_alert_n_oe(alert),
    .o_status(status), .o_port_sel(port_sel)
  );
  dsac_host_model i_host (.i_scl(scl), .i_sda(sda), .o_scl(hs), .o_sda(hd));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // pec: 0 leaves the check byte out, 2 sends it corrupted
  task automatic wr(input logic p, input logic [7:0] c, input int pec);
    i_host.p = p;
    i_host.start(1'b1);
    i_host.send(WA);
    i_host.send(c);
    if (pec > 0)
      i_host.send(i_host.crc ^ ((pec == 2) ? 8'h01 : 8'h00));
    i_host.stop;
    cyc(10);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic [7:0] pe;
    // read-backs wait out a settling time, scaled down to system clock cycles
    cyc(200);
    smax = 0;
    i_host.p = 0;
    i_host.start(1'b1);
    i_host.send(WA);
    i_host.send(c);
    i_host.start(1'b0);
    i_host.send(RA);
    i_host.recv(1'b0, d);
    i_host.recv(1'b1, pe);
    i_host.stop;
    cyc(10);
    chk(i_host.crc === 8'h00 && i_host.nak === 1'b0, "read check");
  endtask
  task automatic t_power;
    chk(alert === 2'b11, "alert after power-up");
    chk(port_sel === 1'b0 && status === 8'h00, "default port");
    chk(scl_oe === 2'b00 && sda_oe === 2'b00, "bus released");
  endtask
  // every condition input but the fan fault is raised here; t_pec raises the fan fault
  task automatic t_fault;
    flt <= 6'h37;
    cyc(5);
    chk(alert === 2'b11 && status === 8'h37, "fault alert");
    wr(1'b0, 8'h03, 1);
    chk(status === 8'h37, "persisting fault kept");
    flt <= 6'h00;
    cyc(5);
    wr(1'b0, 8'h03, 1);
    chk(status === 8'h00 && alert === 2'b11, "refresh alert");
    wr(1'b0, 8'h03, 1);
    chk(alert === 2'b00 && i_host.nak === 1'b0, "alert retired");
  endtask
  task automatic t_pec;
    flt <= 6'h08;
    cyc(2);
    flt <= 6'h00;
    cyc(5);
    chk(alert === 2'b11, "latched alert");
    wr(1'b0, 8'h03, 0);
    chk(status === 8'h08, "clear without check byte");
    wr(1'b0, 8'h03, 2);
    chk(status === 8'h48, "bad check byte");
  endtask
  task automatic t_read;
    logic [7:0] d;
    // the snapshot returns long before the acknowledge ends: no stretch
    rd(8'h78, d);
    chk(d === 8'h48 && smax == 0, "status read");
    busy <= 1'b1;
    rd(8'h20, d);
    busy <= 1'b0;
    chk(d === 8'h00, "unsupported read");
    chk(smax >= 150 && smax <= 215, "stretch limit");
  endtask
  // a shorted port 0 looks like a start, then a stuck bus
  task automatic t_port1;
    // wait past the lock-up limit so the engine is idle again
    i_host.gnd = 2'b01;
    cyc(7000);
    chk(scl_oe === 2'b00 && sda_oe === 2'b00, "lock-up release");
    wr(1'b1, 8'h03, 1);
    chk(i_host.nak === 1'b0 && port_sel === 1'b1, "second port");
    chk(status === 8'h00, "clear from port 1");
    i_host.gnd = 2'b00;
  endtask
  initial
  begin
    cyc(40);
    rst_n <= 1'b1;
    cyc(10);
    t_power;
    t_fault;
    t_pec;
    t_read;
    t_port1;
    report_and_stop;
  end
  initial
  begin
    cyc(150000);
    num_errors++;
    report_and_stop;
  end
endmodule
